//--- verilog/mats_regs.vh
// Behaviour
// - Wait ack at most ack_wait_symbols symbols
// - Ack wait in 16us symbols, resets 0x39
// - Slot ends: guaranteed 7-4, contention 3-0
// - Derive 50 ns tick from clock
// - Nine-bit symbol tick count, resets 0x140
`ifndef MATS_REGS_VH
`define MATS_REGS_VH

// Register indices; byte address is four times the index
`define MATS_IDX_ACK_TIMEOUT_CONTROL 8'h12
`define MATS_IDX_SLOT_END_CONFIG 8'h13
`define MATS_IDX_SYMBOL_TICK_LOW 8'h14
`define MATS_IDX_SYMBOL_TICK_HIGH 8'h15
`define MATS_IDX_ACK_STATUS 8'h20

// Field positions
`define MATS_ACK_PEND_BIT 7
`define MATS_FGS_END_MSB 7
`define MATS_FGS_END_LSB 4
`define MATS_CPE_END_MSB 3
`define MATS_CPE_END_LSB 0
`define MATS_STAT_WAITING_BIT 0
`define MATS_STAT_TIMEOUT_BIT 1

// Reset values
`define MATS_RST_ACK_PEND 1'b0
`define MATS_RST_ACK_WAIT 7'h39
`define MATS_RST_SLOT_END 8'h00
`define MATS_RST_TICK_COUNT 9'h140

// Timing: tick of 50 ns from a 10 ns bus clock
`define MATS_CLK_PERIOD_NS 10
`define MATS_TICK_NS 50
`define MATS_SYMBOL_US 16
`define MATS_TICK_CYC (`MATS_TICK_NS / `MATS_CLK_PERIOD_NS)

`endif

//--- verilog/mats_symbol_tick.v
`timescale 1ns/10ps
`include "mats_regs.vh"

// Tick prescaler and symbol-period divider
module mats_symbol_tick (
  input wire pclk,
  input wire presetn,
  input wire restart,
  input wire [8:0] symbol_tick_count,
  output reg tick_r,
  output reg symbol_r
);

  localparam integer TICK_LAST_I = `MATS_TICK_CYC - 1;
  localparam [2:0] TICK_LAST = TICK_LAST_I[2:0];

  reg [2:0] pre_r;
  reg [8:0] tick_cnt_r;
  wire [8:0] period_last;

  // A zero period would never strobe, so it acts as one tick
  assign period_last = (symbol_tick_count == 9'h000) ? 9'h000 : symbol_tick_count - 9'h001;

  // Prescaler gives one 50 ns tick pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_r <= 3'h0;
      tick_r <= 1'b0;
    end
    else if (restart)
    begin
      pre_r <= 3'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (pre_r == TICK_LAST);
      pre_r <= (pre_r == TICK_LAST) ? 3'h0 : pre_r + 3'h1;
    end
  end

  // Counts ticks; the restart aligns symbols to the start of a wait
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 9'h000;
      symbol_r <= 1'b0;
    end
    else if (restart)
    begin
      tick_cnt_r <= 9'h000;
      symbol_r <= 1'b0;
    end
    else
    begin
      symbol_r <= 1'b0;
      if (tick_r)
      begin
        if (tick_cnt_r >= period_last)
        begin
          tick_cnt_r <= 9'h000;
          symbol_r <= 1'b1;
        end
        else
        begin
          tick_cnt_r <= tick_cnt_r + 9'h001;
        end
      end
    end
  end

endmodule // mats_symbol_tick

//--- verilog/mats_top.v
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
`include "mats_regs.vh"

// MAC ack, slot and symbol timing block with APB register access
module mats_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire frame_sent,
  input wire ack_received,
  input wire data_request_rx,
  output reg ack_frame_pending_r,
  output reg ack_waiting_r,
  output reg ack_timeout_r,
  output wire [3:0] first_guaranteed_slot_end,
  output wire [3:0] contention_period_end_slot
);

  localparam IDLE = 1'b0;
  localparam WAIT = 1'b1;

  // Configuration registers
  reg ack_frame_pending_set_r;
  reg [6:0] ack_wait_symbols_r;
  reg [7:0] slot_end_r;
  reg [8:0] symbol_tick_count_r;
  // Ack wait state
  reg timeout_seen_r;
  reg [6:0] sym_cnt_r;
  reg ack_waiting_nxt;
  reg [6:0] sym_cnt_nxt;
  reg ack_timeout_nxt;
  reg timeout_seen_nxt;
  // Bus side
  reg pready_r;
  reg [31:0] rdata_nxt;
  reg mapped;
  wire [7:0] idx;
  wire wr_en;
  wire access;
  wire access_first;
  wire wr_ack_ctrl;
  wire wr_slot_end;
  wire wr_tick_low;
  wire wr_tick_high;
  wire wr_status;
  // Symbol timing
  wire tick;
  wire symbol;
  wire start_wait;
  wire timeout_hit;

  // Byte address to register index; only aligned words decode
  function [7:0] addr_index;
    input [31:0] a;
    begin
      addr_index = (a[1:0] == 2'b00 && a[31:10] == 22'h00_0000) ? a[9:2] : 8'hff;
    end
  endfunction

  // Write strobe for one register index
  function reg_hit;
    input [7:0] i;
    input [7:0] want;
    begin
      reg_hit = (i == want);
    end
  endfunction

  // Registers are a byte wide; the upper bus bits read as zero
  function [31:0] zext8;
    input [7:0] b;
    begin
      zext8 = {24'h00_0000, b};
    end
  endfunction

  assign idx = addr_index(paddr);
  assign access = psel & penable;
  // One wait state so read data comes from a flip-flop
  assign pready = pready_r;
  assign pslverr = pready_r & ~mapped;
  assign wr_en = access & pready_r & pwrite & mapped;
  // Writes land at the edge where pready is high, never in the first cycle
  assign wr_ack_ctrl = wr_en & reg_hit(idx, `MATS_IDX_ACK_TIMEOUT_CONTROL);
  assign wr_slot_end = wr_en & reg_hit(idx, `MATS_IDX_SLOT_END_CONFIG);
  assign wr_tick_low = wr_en & reg_hit(idx, `MATS_IDX_SYMBOL_TICK_LOW);
  assign wr_tick_high = wr_en & reg_hit(idx, `MATS_IDX_SYMBOL_TICK_HIGH);
  // Status takes only the write-one clear of its timeout bit
  assign wr_status = wr_en & reg_hit(idx, `MATS_IDX_ACK_STATUS);
  assign access_first = access & ~pready_r;
  assign first_guaranteed_slot_end = slot_end_r[`MATS_FGS_END_MSB:`MATS_FGS_END_LSB];
  assign contention_period_end_slot = slot_end_r[`MATS_CPE_END_MSB:`MATS_CPE_END_LSB];

  // Read mux and decode of the mapped indices
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    mapped = 1'b1;
    // Unmapped and unaligned addresses answer with an error and zero data
    case (idx)
      `MATS_IDX_ACK_TIMEOUT_CONTROL:
        rdata_nxt = zext8({ack_frame_pending_set_r, ack_wait_symbols_r});
      `MATS_IDX_SLOT_END_CONFIG:
        rdata_nxt = zext8(slot_end_r);
      `MATS_IDX_SYMBOL_TICK_LOW:
        rdata_nxt = zext8(symbol_tick_count_r[7:0]);
      `MATS_IDX_SYMBOL_TICK_HIGH:
        rdata_nxt = zext8({7'h00, symbol_tick_count_r[8]});
      `MATS_IDX_ACK_STATUS:
        rdata_nxt = zext8({6'h00, timeout_seen_r, ack_waiting_r});
      default:
        mapped = 1'b0;
    endcase
  end

  // APB answer: pready rises in the second access cycle, for one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= access_first;
      // Read data is loaded early so it already stands when pready is high
      if (access_first & ~pwrite)
      begin
        prdata <= rdata_nxt;
      end
    end
  end

  // Pending control bit and ack wait field share one register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_frame_pending_set_r <= `MATS_RST_ACK_PEND;
      ack_wait_symbols_r <= `MATS_RST_ACK_WAIT;
    end
    else if (wr_ack_ctrl)
    begin
      ack_frame_pending_set_r <= pwdata[`MATS_ACK_PEND_BIT];
      ack_wait_symbols_r <= pwdata[6:0];
    end
  end

  // Slot end register; each field is a plain 0 to 15 slot number
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_end_r <= `MATS_RST_SLOT_END;
    end
    else if (wr_slot_end)
    begin
      slot_end_r <= pwdata[7:0];
    end
  end

  // Tick count: low byte and top bit sit in two registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      symbol_tick_count_r <= `MATS_RST_TICK_COUNT;
    end
    else
    begin
      // Changed in two writes, the period is briefly a mix of old and new
      if (wr_tick_low)
      begin
        symbol_tick_count_r[7:0] <= pwdata[7:0];
      end
      if (wr_tick_high)
      begin
        symbol_tick_count_r[8] <= pwdata[0];
      end
    end
  end

  // Frame pending bit is latched when a data request arrives
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_frame_pending_r <= 1'b0;
    end
    else if (data_request_rx)
    begin
      ack_frame_pending_r <= ack_frame_pending_set_r;
    end
  end

  // A new frame restarts the symbol divider so the first symbol is whole
  assign start_wait = frame_sent;
  // Compare with >= so a wait value lowered mid-wait still ends the wait
  assign timeout_hit = (ack_waiting_r == WAIT) && (sym_cnt_r >= ack_wait_symbols_r);

  mats_symbol_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(start_wait),
    .symbol_tick_count(symbol_tick_count_r),
    .tick_r(tick),
    .symbol_r(symbol)
  );

  // Ack wait next state; ack beats a timeout in the same cycle
  always @*
  begin
    ack_waiting_nxt = ack_waiting_r;
    sym_cnt_nxt = sym_cnt_r;
    ack_timeout_nxt = 1'b0;
    case (ack_waiting_r)
      IDLE:
      begin
        // An ack arriving while idle is ignored
        if (start_wait)
        begin
          ack_waiting_nxt = WAIT;
          sym_cnt_nxt = 7'h00;
        end
      end
      WAIT:
      begin
        if (start_wait)
        begin
          // A resent frame opens a fresh wait window
          sym_cnt_nxt = 7'h00;
        end
        else if (ack_received)
        begin
          ack_waiting_nxt = IDLE;
        end
        else if (timeout_hit)
        begin
          ack_waiting_nxt = IDLE;
          ack_timeout_nxt = 1'b1;
        end
        else if (symbol)
        begin
          sym_cnt_nxt = sym_cnt_r + 7'h01;
        end
      end
      default:
        ack_waiting_nxt = IDLE;
    endcase
  end

  // Ack wait registers; the timeout pulse lasts one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_waiting_r <= IDLE;
      sym_cnt_r <= 7'h00;
      ack_timeout_r <= 1'b0;
    end
    else
    begin
      ack_waiting_r <= ack_waiting_nxt;
      sym_cnt_r <= sym_cnt_nxt;
      ack_timeout_r <= ack_timeout_nxt;
    end
  end

  // Sticky timeout flag; a new timeout wins over a write-one clear
  always @*
  begin
    timeout_seen_nxt = timeout_seen_r;
    // Timeout and clear in one cycle: the timeout is kept
    if (ack_timeout_r)
    begin
      timeout_seen_nxt = 1'b1;
    end
    else if (wr_status && pwdata[`MATS_STAT_TIMEOUT_BIT])
    begin
      timeout_seen_nxt = 1'b0;
    end
  end

  // Timeout flag register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_seen_r <= 1'b0;
    end
    else
    begin
      timeout_seen_r <= timeout_seen_nxt;
    end
  end

endmodule // mats_top

//--- bench/mats_assertions.sv
`timescale 1ns/10ps
// Port-level timing checks for the ack, slot and symbol block
module mats_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire frame_sent,
  input wire ack_received,
  input wire data_request_rx,
  input wire ack_frame_pending_r,
  input wire ack_waiting_r,
  input wire ack_timeout_r
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Register access answers in the second access cycle, one cycle wide
  rdy_second_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  rdy_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_rdy_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside an answered access");
  // Pending flag moves only on a data request
  pend_hold_a: assert property (!$past(data_request_rx) |-> $stable(ack_frame_pending_r))
    else $error("pending flag changed without request");
  wait_start_a: assert property (frame_sent |=> ack_waiting_r)
    else $error("no wait after frame sent");
  ack_stop_a: assert property (ack_waiting_r && ack_received && !frame_sent
    |=> !ack_waiting_r && !ack_timeout_r)
    else $error("ack did not end wait");
  to_cause_a: assert property (ack_timeout_r |-> $past(ack_waiting_r) && !ack_waiting_r)
    else $error("timeout without wait");
  to_pulse_a: assert property (ack_timeout_r |=> !ack_timeout_r)
    else $error("timeout longer than one cycle");
endmodule // mats_checker

bind mats_top mats_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .frame_sent, .ack_received, .data_request_rx, .ack_frame_pending_r, .ack_waiting_r,
  .ack_timeout_r);

//--- bench/mats_peer_model.sv
`timescale 1ns/10ps
// Peer radio: acks a waiting sender after reply_delay cycles, 0 stays silent
module mats_peer_model (
  input wire pclk,
  input wire presetn,
  input wire ack_waiting_r,
  input wire [15:0] reply_delay,
  input wire send_req,
  output reg ack_received,
  output reg data_request_rx
);
  reg [15:0] cnt_r;
  // Count only while waiting so one ack goes out per frame
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 16'h0000;
      ack_received <= 1'b0;
      data_request_rx <= 1'b0;
    end
    else
    begin
      data_request_rx <= send_req;
      ack_received <= ack_waiting_r && reply_delay != 16'h0000 && cnt_r == reply_delay;
      cnt_r <= ack_waiting_r ? cnt_r + 16'h0001 : 16'h0000;
    end
  end
endmodule // mats_peer_model

//--- bench/mats_tb.sv
`timescale 1ns/10ps
`include "mats_regs.vh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic frame_sent = 0, send_req = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd_v;
  logic pready, pslverr, ack_received, data_request_rx, pend, waiting, tmo, err_v;
  logic [3:0] gts, cap;
  logic [15:0] reply_delay = 0;
  integer fails = 0, check_count = 0, cyc = 0, tmo_cnt = 0, n, w, p;
  mats_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .frame_sent, .ack_received, .data_request_rx,
    .ack_frame_pending_r(pend), .ack_waiting_r(waiting), .ack_timeout_r(tmo),
    .first_guaranteed_slot_end(gts), .contention_period_end_slot(cap));
  mats_peer_model u_peer (.pclk, .presetn, .ack_waiting_r(waiting), .reply_delay,
    .send_req, .ack_received, .data_request_rx);
  always #5 pclk = ~pclk;
  // Cycle limit and timeout pulse count
  always @(posedge pclk)
  begin
    cyc++;
    if (tmo === 1'b1)
      tmo_cnt++;
    if (cyc == 6000)
    begin
      fails++;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      check_count++;
      if (seen !== exp)
      begin
        fails++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // One transfer; holds the request until pready is seen high, only the cycle limit ends it
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
        @(posedge pclk);
      while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // An idle edge so the next call never drives psel twice in one step
      @(posedge pclk);
    end
  endtask
  // Counts edges until the timeout pulse is seen, with a bound
  task wait_tmo;
    begin
      n = 0;
      while (tmo !== 1'b1 && n < 200)
      begin
        @(posedge pclk);
        n++;
      end
    end
  endtask
  task frame;
    begin
      frame_sent <= 1'b1;
      @(posedge pclk);
      frame_sent <= 1'b0;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `MATS_IDX_ACK_TIMEOUT_CONTROL, 0);
    chk(rd_v, 32'h0000_0039);
    apb(0, `MATS_IDX_SLOT_END_CONFIG, 0);
    chk(rd_v, 32'h0000_0000);
    apb(0, `MATS_IDX_SYMBOL_TICK_LOW, 0);
    chk(rd_v, 32'h0000_0040);
    apb(0, `MATS_IDX_SYMBOL_TICK_HIGH, 0);
    chk(rd_v, 32'h0000_0001);
    apb(1, `MATS_IDX_SLOT_END_CONFIG, 32'h0000_00A5);
    apb(0, `MATS_IDX_SLOT_END_CONFIG, 0);
    chk(rd_v, 32'h0000_00A5);
    chk({24'h0, gts, cap}, 32'h0000_00A5);
    // Unmapped index is refused with error and zero data
    apb(0, 8'h30, 0);
    chk({rd_v[30:0], err_v}, 32'h0000_0001);
    for (p = 1; p >= 0; p--)
    begin
      apb(1, `MATS_IDX_ACK_TIMEOUT_CONTROL, {24'h0, p[0], 7'h39});
      send_req <= 1'b1;
      @(posedge pclk);
      send_req <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(pend, p[0]);
    end
    // Two ticks per symbol: timeout near 10 cycles per symbol of wait
    apb(1, `MATS_IDX_SYMBOL_TICK_LOW, 32'h0000_0002);
    apb(1, `MATS_IDX_SYMBOL_TICK_HIGH, 32'h0000_0000);
    for (w = 1; w <= 4; w += 3)
    begin
      apb(1, `MATS_IDX_ACK_TIMEOUT_CONTROL, w);
      frame;
      wait_tmo;
      chk(n >= w * 10 && n <= w * 10 + 6, 1);
    end
    apb(0, `MATS_IDX_ACK_TIMEOUT_CONTROL, 0);
    chk(rd_v, 32'h0000_0004);
    // A timeout leaves the sticky flag; writing one clears it
    apb(0, `MATS_IDX_ACK_STATUS, 0);
    chk(rd_v, 32'h0000_0002);
    apb(1, `MATS_IDX_ACK_STATUS, 32'h0000_0002);
    apb(0, `MATS_IDX_ACK_STATUS, 0);
    chk(rd_v, 32'h0000_0000);
    // Peer answers before the wait runs out
    reply_delay <= 16'h000A;
    w = tmo_cnt;
    frame;
    apb(0, `MATS_IDX_ACK_STATUS, 0);
    chk(rd_v, 32'h0000_0001);
    repeat (80) @(posedge pclk);
    chk(tmo_cnt - w, 0);
    chk(waiting, 0);
    // A resent frame restarts the wait window
    reply_delay <= 16'h0000;
    apb(1, `MATS_IDX_ACK_TIMEOUT_CONTROL, 32'h0000_0001);
    frame;
    repeat (7) @(posedge pclk);
    frame;
    wait_tmo;
    chk(n >= 10 && n <= 16, 1);
    report_and_stop;
  end
endmodule // tb
